// file: pmta_pkg.sv
/*
  pmta_pkg: constants for the program memory and table read unit.
  assumes a 20 MHz instruction clock and a 13-bit word address.
*/
package pmta_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DEPTH = 8192;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam int unsigned TBL_HI_BITS = 5;
  localparam int unsigned HI_STORE_BITS = 8;
  localparam logic [1:0] TBL_CYCLES = 2'h2;
  // link command codes
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam int unsigned FRAME_BITS = 32;
  typedef enum logic [1:0] {pmta_idle_t_i, pmta_fetch, pmta_done}
    pmta_tbl_t;
endpackage : pmta_pkg

// file: pmta_program_memory.sv
/*
  pmta_program_memory: 8K x 16 program store, program counter, table
  pointer and table read path, plus a serial programming/debug link.
  assumes: the core sequences fetches via pc_advance/pc_load, and the
  programmer or debug adapter drives the clock pin, and the data pin outside read data slots.
*/
`timescale 1ns/100ps
// Overview of operation
// R1 - 8K by 16 program store, PC addressed
// R2 - reset loads program counter with zero
// R3 - table pointer separate from program counter
// R4 - table address from low and high pointers
// R5 - low table byte to operand register
// R6 - high table byte to high latch
// R7 - unstored high latch bits read zero
// R8 - high latch read-only, writes ignored
// R9 - table instructions take two cycles
// R10 - programming link: bidirectional data, external clock
// R11 - other outputs stay off link pins
// R12 - debug link: bidirectional data, input clock
// R13 - emulation variant: shared pin functions disabled
// R14 - low pointer bits 7:0, high 12:8
// R15 - high latch changes only on table read
module pmta_program_memory (
  input wire logic clock, // instruction clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic link_clock, // serial clock from programmer/adapter
  input wire logic emulation_mode, // strap: debug link owns pins
  input wire logic pc_advance, // core: step to next instruction
  input wire logic pc_load, // core: branch
  input wire logic [12:0] pc_target, // branch target
  input wire logic tbl_ptr_low_we, // write table pointer low
  input wire logic tbl_ptr_high_we, // write table pointer high
  input wire logic tbl_latch_we, // attempted write to high latch
  input wire logic [7:0] wr_data, // software write data
  input wire logic tbl_read, // start table read instruction
  input wire logic [7:0] tbl_operand, // destination register address
  input wire logic pin_data_in, // serial data pin level
  input wire logic func_out, // shared pin normal function output
  input wire logic func_oe, // shared pin normal function enable
  output logic [12:0] pc, // program counter
  output logic [15:0] instr_word, // fetched instruction
  output logic [7:0] tbl_ptr_low, // table pointer low
  output logic [7:0] tbl_ptr_high, // table pointer high (read view)
  output logic [7:0] table_high_byte_latch, // high byte latch
  output logic tbl_busy, // table instruction in its first cycle
  output logic dm_we, // write strobe to data memory
  output logic [7:0] dm_addr, // data memory address
  output logic [7:0] dm_data, // low table byte
  output logic pin_data_out, // serial data pin drive
  output logic pin_data_oe, // serial data pin enable
  output logic pin_func_out, // shared function pin drive
  output logic pin_func_oe // shared function pin enable
);
  logic [15:0] mem [0:pmta_pkg::DEPTH-1]; // R1
  logic [12:0] next_pc;
  logic [15:0] next_instr_word;
  logic [7:0] next_tbl_ptr_low;
  logic [4:0] tbl_hi, next_tbl_hi;
  logic [7:0] next_latch;
  pmta_pkg::pmta_tbl_t tstate, next_tstate;
  logic next_tbl_busy, next_dm_we;
  logic [7:0] next_dm_addr, next_dm_data;
  logic [7:0] op_hold, next_op_hold;
  logic [15:0] tword;
  logic pin_func_out_r, pin_func_oe_r;
  logic next_pin_func_out, next_pin_func_oe;
  // link words delivered to the memory domain
  logic [12:0] lk_addr;
  logic [15:0] lk_wdata;
  logic lk_tog_s1, lk_tog_s2, lk_tog_s3, lk_tog_s4;
  logic lk_wr_pulse;
  // last written word, read by the link side; it only moves a few
  // clocks after a write frame, while the link clock stands still
  logic [15:0] rd_word;

  function automatic logic [12:0] tbl_addr(input logic [4:0] hi,
                                           input logic [7:0] lo);
    tbl_addr = {hi, lo}; // R4 R14
  endfunction : tbl_addr

  assign tword = mem[tbl_addr(tbl_hi, tbl_ptr_low)];

  // program counter and fetch; reset vector on reset
  always_comb
  begin
    next_pc = pc;
    if (pc_load)
      next_pc = pc_target;
    else if (pc_advance)
      next_pc = pc + 13'h0001;
    next_instr_word = mem[pc]; // R1
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pc <= pmta_pkg::RESET_VECTOR; // R2
      instr_word <= 16'h0000;
    end
    else
    begin
      pc <= next_pc;
      instr_word <= next_instr_word;
    end
  end

  // table pointer and two-cycle table read sequence
  always_comb
  begin
    next_tbl_ptr_low = tbl_ptr_low;
    next_tbl_hi = tbl_hi;
    next_latch = table_high_byte_latch; // R8 R15
    next_tstate = tstate;
    next_tbl_busy = 1'b0;
    next_dm_we = 1'b0;
    next_dm_addr = dm_addr;
    next_dm_data = dm_data;
    next_op_hold = op_hold;
    if (tbl_ptr_low_we)
      next_tbl_ptr_low = wr_data; // R3
    if (tbl_ptr_high_we)
      next_tbl_hi = wr_data[4:0];
    unique case (tstate)
      pmta_pkg::pmta_idle_t_i:
      begin
        if (tbl_read)
        begin
          next_tstate = pmta_pkg::pmta_fetch; // R9
          next_op_hold = tbl_operand;
          next_tbl_busy = 1'b1;
        end
      end
      pmta_pkg::pmta_fetch:
      begin
        next_dm_we = 1'b1; // R5
        next_dm_addr = op_hold;
        next_dm_data = tword[7:0];
        next_latch = tword[15:8]; // R6 R7
        next_tstate = pmta_pkg::pmta_done;
      end
      pmta_pkg::pmta_done:
        next_tstate = pmta_pkg::pmta_idle_t_i;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tbl_ptr_low <= 8'h00;
      tbl_hi <= 5'h00;
      table_high_byte_latch <= 8'h00;
      tstate <= pmta_pkg::pmta_idle_t_i;
      tbl_busy <= 1'b0;
      dm_we <= 1'b0;
      dm_addr <= 8'h00;
      dm_data <= 8'h00;
      op_hold <= 8'h00;
    end
    else
    begin
      tbl_ptr_low <= next_tbl_ptr_low;
      tbl_hi <= next_tbl_hi;
      table_high_byte_latch <= next_latch;
      tstate <= next_tstate;
      tbl_busy <= next_tbl_busy;
      dm_we <= next_dm_we;
      dm_addr <= next_dm_addr;
      dm_data <= next_dm_data;
      op_hold <= next_op_hold;
    end
  end

  // unstored pointer bits read back as zero
  assign tbl_ptr_high = {3'h0, tbl_hi};

  // memory write from link, word and address stable before the pulse
  always_ff @(posedge clock)
  begin
    if (lk_wr_pulse)
      mem[lk_addr] <= lk_wdata; // R10
  end

  // write toggle taken across by two flops; the edge is found one flop
  // later, so nothing reads the first, possibly metastable, stage
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lk_tog_s2 <= 1'b0;
      lk_tog_s3 <= 1'b0;
      lk_tog_s4 <= 1'b0;
      rd_word <= 16'h0000;
    end
    else
    begin
      lk_tog_s2 <= lk_tog_s1;
      lk_tog_s3 <= lk_tog_s2;
      lk_tog_s4 <= lk_tog_s3;
      if (lk_wr_pulse)
        rd_word <= lk_wdata; // R10
    end
  end
  assign lk_wr_pulse = lk_tog_s3 ^ lk_tog_s4;

  // shared pin: normal function is muted while emulating
  always_comb
  begin
    next_pin_func_out = func_out;
    next_pin_func_oe = func_oe;
    if (emulation_mode)
    begin
      next_pin_func_out = 1'b0; // R13
      next_pin_func_oe = 1'b0; // R11
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pin_func_out_r <= 1'b0;
      pin_func_oe_r <= 1'b0;
    end
    else
    begin
      pin_func_out_r <= next_pin_func_out;
      pin_func_oe_r <= next_pin_func_oe;
    end
  end
  assign pin_func_out = pin_func_out_r;
  assign pin_func_oe = pin_func_oe_r;

  // link domain: 32-bit frame, cmd[1:0] addr[12:0] pad data[15:0]
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [31:0] shreg, next_shreg;
  logic lk_tog, next_lk_tog;
  logic [12:0] next_lk_addr;
  logic [15:0] next_lk_wdata;
  logic lk_dout, next_lk_dout;
  logic lk_oe, next_lk_oe;
  logic rd_frame, next_rd_frame;
  logic rst_l1, rst_l2;

  // link logic has its own reset, taken across by two flops
  always_ff @(posedge link_clock)
  begin
    rst_l1 <= rst_n;
    rst_l2 <= rst_l1;
  end

  // the link clock only runs inside frames, so no idle edges assumed
  always_comb
  begin
    next_shreg = {shreg[30:0], pin_data_in}; // R12
    next_bit_cnt = bit_cnt + 6'h01;
    next_lk_tog = lk_tog;
    next_lk_addr = lk_addr;
    next_lk_wdata = lk_wdata;
    next_lk_dout = lk_dout;
    next_lk_oe = 1'b0;
    next_rd_frame = rd_frame;
    if (bit_cnt == 6'h01)
      next_rd_frame = ({shreg[0], pin_data_in} == pmta_pkg::CMD_READ);
    if (bit_cnt == 6'(pmta_pkg::FRAME_BITS - 1))
    begin
      next_bit_cnt = 6'h00;
      // a read frame leaves the write pair alone, so a toggle replayed
      // after a clock-side reset only rewrites the same word in place
      if (shreg[30:29] == pmta_pkg::CMD_WRITE)
      begin
        next_lk_addr = shreg[28:16];
        next_lk_wdata = {shreg[14:0], pin_data_in};
        next_lk_tog = ~lk_tog;
      end
    end
    // drive the 16 data slots of a read frame only, each set up one edge
    // ahead of the edge that samples it; released after the last slot
    if (rd_frame && bit_cnt >= 6'h0f && bit_cnt <= 6'h1e)
    begin
      next_lk_oe = 1'b1; // R12
      next_lk_dout = rd_word[4'(6'h1e - bit_cnt)];
    end
  end

  always_ff @(posedge link_clock)
  begin
    if (!rst_l2)
    begin
      shreg <= 32'h00000000;
      bit_cnt <= 6'h00;
      lk_tog <= 1'b0;
      lk_addr <= 13'h0000;
      lk_wdata <= 16'h0000;
      lk_dout <= 1'b0;
      lk_oe <= 1'b0;
      rd_frame <= 1'b0;
    end
    else
    begin
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      lk_tog <= next_lk_tog;
      lk_addr <= next_lk_addr;
      lk_wdata <= next_lk_wdata;
      lk_dout <= next_lk_dout;
      lk_oe <= next_lk_oe;
      rd_frame <= next_rd_frame;
    end
  end
  assign lk_tog_s1 = lk_tog;
  assign pin_data_out = lk_dout;
  assign pin_data_oe = lk_oe;
endmodule : pmta_program_memory

// file: pmta_link_host.sv
/* pmta_link_host: programmer model at the serial link pins.
   assumes the device samples data on the rising link clock. */
`timescale 1ns/100ps
module pmta_link_host (
  output logic link_clock, // serial clock, still between frames
  output logic pin_data_in, // wire level seen by the device
  input wire logic pin_data_out, // device drive
  input wire logic pin_data_oe // device drive enable
);
  logic drv;
  logic [31:0] seen; // line level at each rising edge, last bit in bit 0
  // wire level: the device wins while it drives
  assign pin_data_in = pin_data_oe ? pin_data_out : drv;
  initial
  begin
    link_clock = 1'b0;
    drv = 1'b0;
    seen = 32'h00000000;
  end
  // n bits msb first; clock only moves inside the burst
  task shift(input logic [31:0] f, input int n);
    for (int i = 31; i > 31 - n; i--)
    begin
      drv = f[i];
      #15 seen = {seen[30:0], pin_data_in};
      link_clock = 1'b1;
      #15 link_clock = 1'b0;
    end
    drv = ~drv; // released line must not hold a stale level
  endtask : shift
endmodule : pmta_link_host

// file: pmta_checker.sv
/* pmta_checker: timing properties of the table path, program counter and pins.
   assumes it is bound to pmta_program_memory. */
`timescale 1ns/100ps
module pmta_checker (
  input wire logic clock, // instruction clock
  input wire logic rst_n, // sync reset, active low
  input wire logic emulation_mode, // debug link owns pins
  input wire logic pc_load, // branch request
  input wire logic [12:0] pc_target, // branch target
  input wire logic tbl_ptr_high_we, // pointer high write
  input wire logic [7:0] wr_data, // software write data
  input wire logic tbl_read, // table read start
  input wire logic [7:0] tbl_operand, // destination address
  input wire logic [12:0] pc, // program counter
  input wire logic [7:0] tbl_ptr_high, // pointer high view
  input wire logic [7:0] table_high_byte_latch, // high byte latch
  input wire logic tbl_busy, // first table cycle
  input wire logic dm_we, // data memory strobe
  input wire logic [7:0] dm_addr, // data memory address
  input wire logic pin_func_oe // shared pin enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic go;
  // a read is taken only while the unit is idle
  assign go = tbl_read && !tbl_busy && !dm_we;
  sequence s_walk;
    tbl_busy ##1 dm_we;
  endsequence
  AST_TBL_TWO: assert property (go |=> s_walk)
    else $error("table read not done in two cycles");
  property p_dm_addr;
    go |-> ##2 dm_addr == $past(tbl_operand, 2);
  endproperty
  property p_latch_hold;
    !dm_we |-> $stable(table_high_byte_latch);
  endproperty
  property p_ptr_hi;
    tbl_ptr_high_we |=> tbl_ptr_high == {3'h0, $past(wr_data[4:0])};
  endproperty
  AST_DM_ADDR: assert property (p_dm_addr)
    else $error("table low byte sent to wrong register");
  AST_BUSY_PULSE: assert property (tbl_busy |=> !tbl_busy)
    else $error("busy longer than one cycle");
  AST_LATCH_HOLD: assert property (p_latch_hold)
    else $error("high latch changed outside a table read");
  AST_PTR_HI: assert property (p_ptr_hi)
    else $error("pointer high not loaded with its five bits");
  AST_PC_LOAD: assert property (pc_load |=> pc == $past(pc_target))
    else $error("branch target not loaded");
  AST_PC_RST: assert property ($rose(rst_n) |-> pc == 13'h0000)
    else $error("program counter not at reset vector");
  AST_EMU: assert property (emulation_mode[*2] |=> !pin_func_oe)
    else $error("shared pin driven in emulation mode");
endmodule : pmta_checker

// file: tb.sv
/* tb: table read, fetch, reset, link write/read and shared pin tests.
   assumes the link host model owns the serial pins. */
`timescale 1ns/100ps
module tb;
  logic clock, rst_n, emulation_mode, pc_advance, pc_load, tbl_read;
  logic tbl_ptr_low_we, tbl_ptr_high_we, tbl_latch_we, func_out, func_oe;
  logic [12:0] pc_target, pc;
  logic [7:0] wr_data, tbl_operand, tbl_ptr_low, tbl_ptr_high, dm_addr;
  logic [7:0] table_high_byte_latch, dm_data;
  logic [15:0] instr_word;
  logic tbl_busy, dm_we, pin_func_out, pin_func_oe;
  logic link_clock, pin_data_in, pin_data_out, pin_data_oe;
  int n_mismatch, checks;
  pmta_program_memory dut (
    .clock(clock),
    .rst_n(rst_n),
    .link_clock(link_clock),
    .emulation_mode(emulation_mode),
    .pc_advance(pc_advance),
    .pc_load(pc_load),
    .pc_target(pc_target),
    .tbl_ptr_low_we(tbl_ptr_low_we),
    .tbl_ptr_high_we(tbl_ptr_high_we),
    .tbl_latch_we(tbl_latch_we),
    .wr_data(wr_data),
    .tbl_read(tbl_read),
    .tbl_operand(tbl_operand),
    .pin_data_in(pin_data_in),
    .func_out(func_out),
    .func_oe(func_oe),
    .pc(pc),
    .instr_word(instr_word),
    .tbl_ptr_low(tbl_ptr_low),
    .tbl_ptr_high(tbl_ptr_high),
    .table_high_byte_latch(table_high_byte_latch),
    .tbl_busy(tbl_busy),
    .dm_we(dm_we),
    .dm_addr(dm_addr),
    .dm_data(dm_data),
    .pin_data_out(pin_data_out),
    .pin_data_oe(pin_data_oe),
    .pin_func_out(pin_func_out),
    .pin_func_oe(pin_func_oe)
  );
  pmta_link_host host (
    .link_clock(link_clock),
    .pin_data_in(pin_data_in),
    .pin_data_out(pin_data_out),
    .pin_data_oe(pin_data_oe)
  );
  // clock at 20 MHz
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clock);
  endtask : step
  task end_sim;
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // link write; commit lands a few clocks after the frame
  task t_wr(input logic [12:0] a, input logic [15:0] w);
    host.shift({pmta_pkg::CMD_WRITE, a, 1'b0, w}, 32);
    step(8);
  endtask : t_wr
  // pointer setup then one table read, checked on its answer cycle
  task t_tbl(input logic [12:0] a, input logic [15:0] w);
    step(1);
    wr_data <= a[7:0];
    tbl_ptr_low_we <= 1'b1;
    step(1);
    tbl_ptr_low_we <= 1'b0;
    tbl_ptr_high_we <= 1'b1;
    wr_data <= {3'h0, a[12:8]};
    step(1);
    tbl_ptr_high_we <= 1'b0;
    tbl_read <= 1'b1;
    tbl_operand <= ~a[7:0];
    step(1);
    tbl_read <= 1'b0;
    #1;
    chk({15'h0, tbl_busy}, 16'h0001, "tbl_busy");
    step(1);
    #1;
    chk({15'h0, dm_we}, 16'h1, "dm_we");
    chk({8'h0, dm_addr}, {8'h0, ~a[7:0]}, "dm_addr");
    chk({8'h0, dm_data}, {8'h0, w[7:0]}, "dm_data");
    chk({8'h0, table_high_byte_latch}, {8'h0, w[15:8]}, "latch");
    chk({tbl_ptr_high, tbl_ptr_low}, {3'h0, a}, "pointer");
  endtask : t_tbl
  // writes to the latch and pointer must leave the latch alone
  task t_ro(input logic [7:0] held);
    step(1);
    tbl_latch_we <= 1'b1;
    wr_data <= ~held;
    step(1);
    tbl_latch_we <= 1'b0;
    tbl_ptr_low_we <= 1'b1;
    step(1);
    tbl_ptr_low_we <= 1'b0;
    step(2);
    #1;
    chk({8'h0, table_high_byte_latch}, {8'h0, held}, "latch_ro");
  endtask : t_ro
  // branch, then the fetched word one cycle later
  task t_fetch(input logic [12:0] a, input logic [15:0] w);
    step(1);
    pc_load <= 1'b1;
    pc_target <= a;
    step(1);
    pc_load <= 1'b0;
    step(1);
    #1;
    chk({3'h0, pc}, {3'h0, a}, "pc");
    chk(instr_word, w, "instr_word");
    step(1);
    pc_advance <= 1'b1;
    step(1);
    pc_advance <= 1'b0;
    #1;
    chk({3'h0, pc}, {3'h0, a + 13'h0001}, "pc_step");
  endtask : t_fetch
  // link read: the data slots carry the last word written over the link
  task t_rd(input logic [12:0] a, input logic [15:0] w);
    host.shift({pmta_pkg::CMD_READ, a, 1'b0, 16'h0000}, 32);
    chk(host.seen[15:0], w, "link_read");
    chk({15'h0, pin_data_oe}, 16'h0000, "link_release");
  endtask : t_rd
  // mid-run reset must send the program counter back to the vector
  task t_rst;
    step(1);
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    step(2);
    #1;
    chk({3'h0, pc}, 16'h0000, "pc_rerun");
  endtask : t_rst
  // shared pin passes through, then is muted in emulation
  task t_emu(input logic emu, input logic [15:0] exp);
    step(1);
    func_oe <= 1'b1;
    func_out <= 1'b1;
    emulation_mode <= emu;
    step(4);
    #1;
    chk({14'h0, pin_func_oe, pin_func_out}, exp, "pin_func");
  endtask : t_emu
  initial
  begin
    {rst_n, emulation_mode, pc_advance, pc_load, tbl_read} = '0;
    {tbl_ptr_low_we, tbl_ptr_high_we, tbl_latch_we, func_out, func_oe} = '0;
    {pc_target, wr_data, tbl_operand} = '0;
    fork
    begin
      #1;
      host.shift(32'h0, 4);
    end
    join_none
    step(3);
    rst_n <= 1'b1;
    host.shift(32'h0, 2);
    #1;
    chk({3'h0, pc}, 16'h0000, "pc_reset");
    t_wr(13'h1f06, 16'h3c1a);
    t_wr(13'h0000, 16'ha5c3);
    t_wr(13'h1fff, 16'h00ff);
    t_rd(13'h1fff, 16'h00ff);
    t_tbl(13'h1f06, 16'h3c1a);
    t_tbl(13'h0000, 16'ha5c3);
    t_tbl(13'h1fff, 16'h00ff);
    t_ro(8'h00);
    t_fetch(13'h1f06, 16'h3c1a);
    t_rst();
    t_emu(1'b0, 16'h0003);
    t_emu(1'b1, 16'h0000);
    end_sim();
  end
  // watchdog well beyond the few microseconds the tests take
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb
bind pmta_program_memory pmta_checker chk (
  .clock(clock),
  .rst_n(rst_n),
  .emulation_mode(emulation_mode),
  .pc_load(pc_load),
  .pc_target(pc_target),
  .tbl_ptr_high_we(tbl_ptr_high_we),
  .wr_data(wr_data),
  .tbl_read(tbl_read),
  .tbl_operand(tbl_operand),
  .pc(pc),
  .tbl_ptr_high(tbl_ptr_high),
  .table_high_byte_latch(table_high_byte_latch),
  .tbl_busy(tbl_busy),
  .dm_we(dm_we),
  .dm_addr(dm_addr),
  .pin_func_oe(pin_func_oe)
);
